// ### design/adc_serial_sequencer_fifo.sv
/*
 * Digital control of a 16-input successive-approximation converter:
 * command decode, clock modes, scan sequencing, result formatting, result
 * storage with a temperature slot, and the end-of-conversion flag.
 * Assumes an analog core that answers each conv_start_o pulse with one
 * conv_done_i pulse and a signed code; serial pins come from the host.
 */
// Function
// - sample input rising, change output falling
// - transaction opens with eight-bit command, MSB first
// - select fall starts command input
// - setup bits 5:4 pick mode; oscillator
// - mode 00 start pulse runs whole sequence
// - mode 01 start pulse converts one channel
// - mode 10 default; conversion command starts
// - mode 11 serial-clock timed, no scan/averaging
// - modes 00/10 flag low after last operation
// - mode 01 flag low after each conversion
// - flag high on select/start fall; mode 11
// - bipolar and temperature two's complement, else binary
// - pairs are even positive, next odd negative
// - shared pin has one role at once
// - setup bits 1:0 address pairing registers
// - unipolar negative difference gives zero
// - single-ended always unipolar to ground
// - sixteen results plus temperature; oldest overwritten
// - two-byte results, zero padded, MSB first
// - temperature read first; newer replaces older
// - output released while deselected
// - command MSB one means conversion write
`timescale 1ns/1ps
module adc_serial_sequencer_fifo (
	input  wire logic                              core_clk_i,
	input  wire logic                              rst_n_i,
	input  wire logic                              sclk_i,
	input  wire logic                              cs_n_i,
	input  wire logic                              din_i,
	output logic                                   dout_o,
	output logic                                   dout_oe_o,
	output logic                                   eoc_n_o,
	input  wire logic                              conversion_start_n_i,
	output logic                                   conv_start_o,
	output logic [3:0]                             conv_channel_o,
	output logic                                   conv_diff_o,
	output logic                                   conv_temp_o,
	input  wire logic                              conv_done_i,
	input  wire logic signed [adc_seq_pkg::CODE_W-1:0] conv_code_i,
	output logic                                   osc_en_o,
	output logic                                   sclk_timed_o,
	output logic                                   start_pin_role_o,
	output logic                                   ref_pin_role_o
);

	logic [1:0]  mode_r;
	logic [1:0]  refsel_r;
	logic [1:0]  pair_tgt_r;
	logic [7:0]  uni_r;
	logic [7:0]  bip_r;
	logic [7:0]  conv_r;
	logic [1:0]  nscan_r;
	logic [2:0]  cnv_r;
	logic [15:0] mem_r [adc_seq_pkg::FIFO_DEPTH];
	logic [3:0]  wr_ptr_r;
	logic [3:0]  rd_ptr_r;
	logic [4:0]  count_r;
	logic        rd_lo_r;
	logic [15:0] temp_word_r;
	logic        temp_valid_r;
	logic        temp_lo_r;
	adc_seq_pkg::seq_state_type state_r;
	logic [3:0]  cur_r;
	logic        do_temp_r;
	logic [4:0]  rep_r;
	logic        open_r;
	logic        cur_temp_r;
	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        rx_first;
	logic        cs_fall;
	logic        tx_pop;
	logic [7:0]  tx_byte;
	logic        cnv_fall;
	logic        start_cmd;
	logic        seq_done;
	logic        push;
	logic        pop_fifo;
	logic [15:0] head;
	logic [3:0]  nch;
	logic [7:0]  cmd_byte;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic pair_diff(input logic [3:0] ch, input logic [7:0] u,
		input logic [7:0] b);
		pair_diff = u[~ch[3:1]] | b[~ch[3:1]]; // Bit 7 is pair 0/1
	endfunction : pair_diff

	function automatic logic ch_blocked(input logic [3:0] ch, input logic d,
		input logic sp, input logic rp);
		logic hit_s;
		logic hit_r;
		hit_s = (ch == adc_seq_pkg::CH_START_PIN) ||
			(d && {ch[3:1], 1'b1} == adc_seq_pkg::CH_START_PIN);
		hit_r = (ch == adc_seq_pkg::CH_REF_PIN) ||
			(d && {ch[3:1], 1'b0} == adc_seq_pkg::CH_REF_PIN);
		ch_blocked = (sp && hit_s) || (rp && hit_r);
	endfunction : ch_blocked

	function automatic logic [15:0] fmt_result(
		input logic signed [adc_seq_pkg::CODE_W-1:0] c, input logic twos);
		logic [11:0] v;
		v = c[11:0];
		if (!twos && c[adc_seq_pkg::CODE_W-1])
			v = 12'h000;
		fmt_result = {adc_seq_pkg::LEAD_ZEROS, v};
	endfunction : fmt_result

	////////////////////////////////////////////////////////////////////////
	// Serial front end
	serial_port u_port (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.sclk_i     (sclk_i),
		.cs_n_i     (cs_n_i),
		.din_i      (din_i),
		.tx_byte_i  (tx_byte),
		.tx_pop_o   (tx_pop),
		.rx_byte_o  (rx_byte),
		.rx_valid_o (rx_valid),
		.rx_first_o (rx_first),
		.cs_fall_o  (cs_fall),
		.dout_o     (dout_o),
		.dout_oe_o  (dout_oe_o)
	);

	// Start pin: two flops, third for edge; only heard in pin modes
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			cnv_r <= 3'h7;
		else
			cnv_r <= {cnv_r[1:0], conversion_start_n_i};
	end

	assign cnv_fall = start_pin_role_o && cnv_r[2] && !cnv_r[1];
	assign start_pin_role_o = (mode_r == adc_seq_pkg::MODE_PIN_SEQ) ||
		(mode_r == adc_seq_pkg::MODE_PIN_SINGLE);
	assign ref_pin_role_o = (refsel_r == adc_seq_pkg::REFSEL_EXT_DIFF);
	assign osc_en_o     = (mode_r != adc_seq_pkg::MODE_SCLK);
	assign sclk_timed_o = (mode_r == adc_seq_pkg::MODE_SCLK);

	////////////////////////////////////////////////////////////////////////
	// Command decode
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mode_r     <= adc_seq_pkg::MODE_RST;
			refsel_r   <= adc_seq_pkg::REFSEL_RST;
			pair_tgt_r <= 2'b00;
			uni_r      <= adc_seq_pkg::PAIR_RST;
			bip_r      <= adc_seq_pkg::PAIR_RST;
			conv_r     <= adc_seq_pkg::CONV_RST;
			nscan_r    <= adc_seq_pkg::NSCAN_RST;
		end else if (rx_valid) begin
			pair_tgt_r <= 2'b00;
			if (!rx_first) begin
				if (pair_tgt_r == adc_seq_pkg::DIFFSEL_UNI)
					uni_r <= rx_byte;
				else if (pair_tgt_r == adc_seq_pkg::DIFFSEL_BIP)
					bip_r <= rx_byte;
			end else if (rx_byte[adc_seq_pkg::CONV_FLAG]) begin
				conv_r <= rx_byte;
			end else if (rx_byte[7:6] == adc_seq_pkg::PFX_SETUP) begin
				mode_r     <= rx_byte[adc_seq_pkg::MODE_HI:adc_seq_pkg::MODE_LO];
				refsel_r   <= rx_byte[adc_seq_pkg::REF_HI:adc_seq_pkg::REF_LO];
				pair_tgt_r <= rx_byte[adc_seq_pkg::DIFF_HI:adc_seq_pkg::DIFF_LO];
			end else if (rx_byte[7:5] == adc_seq_pkg::PFX_AVG) begin
				nscan_r <= rx_byte[adc_seq_pkg::NSCAN_HI:adc_seq_pkg::NSCAN_LO];
			end else if (rx_byte[7:4] == adc_seq_pkg::PFX_RST &&
				!rx_byte[adc_seq_pkg::RESET_BIT]) begin
				mode_r   <= adc_seq_pkg::MODE_RST;
				refsel_r <= adc_seq_pkg::REFSEL_RST;
				uni_r    <= adc_seq_pkg::PAIR_RST;
				bip_r    <= adc_seq_pkg::PAIR_RST;
				conv_r   <= adc_seq_pkg::CONV_RST;
				nscan_r  <= adc_seq_pkg::NSCAN_RST;
			end
		end
	end

	// Serial start only in modes 10 and 11
	assign start_cmd = rx_valid && rx_first && rx_byte[adc_seq_pkg::CONV_FLAG] &&
		!start_pin_role_o;
	assign cmd_byte = start_cmd ? rx_byte : conv_r; // Register not loaded yet

	////////////////////////////////////////////////////////////////////////
	// Scan sequencer
	assign nch = cur_r + (pair_diff(cur_r, uni_r, bip_r) ? 4'h2 : 4'h1);
	always_comb begin
		seq_done = 1'b1;
		if (mode_r != adc_seq_pkg::MODE_SCLK) begin
			case (conv_r[adc_seq_pkg::SCAN_HI:adc_seq_pkg::SCAN_LO])
				adc_seq_pkg::SCAN_TO_N:
					seq_done = (nch > conv_r[adc_seq_pkg::CHSEL_HI:adc_seq_pkg::CHSEL_LO]) ||
						(nch == adc_seq_pkg::CH_FIRST);
				adc_seq_pkg::SCAN_FROM_N:
					seq_done = (nch <= cur_r);
				adc_seq_pkg::SCAN_REPEAT:
					seq_done = (rep_r <= 5'd1);
				default:
					seq_done = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r      <= adc_seq_pkg::ST_IDLE;
			cur_r        <= adc_seq_pkg::CH_FIRST;
			do_temp_r    <= 1'b0;
			rep_r        <= 5'd0;
			open_r       <= 1'b0;
			cur_temp_r   <= 1'b0;
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			case (state_r)
				adc_seq_pkg::ST_IDLE: begin
					if (start_cmd || (cnv_fall && !(open_r &&
						mode_r == adc_seq_pkg::MODE_PIN_SINGLE))) begin
						cur_r <= (cmd_byte[adc_seq_pkg::SCAN_HI:adc_seq_pkg::SCAN_LO] ==
							adc_seq_pkg::SCAN_TO_N && !sclk_timed_o) ? adc_seq_pkg::CH_FIRST :
							cmd_byte[adc_seq_pkg::CHSEL_HI:adc_seq_pkg::CHSEL_LO];
						do_temp_r <= cmd_byte[adc_seq_pkg::TEMP_BIT];
						rep_r     <= adc_seq_pkg::REPEAT_STEP * ({3'h0, nscan_r} + 5'd1);
						open_r    <= 1'b1;
						state_r   <= adc_seq_pkg::ST_ISSUE;
					end else if (cnv_fall) begin
						state_r <= adc_seq_pkg::ST_ISSUE;
					end
				end
				adc_seq_pkg::ST_ISSUE: begin
					cur_temp_r <= do_temp_r;
					if (do_temp_r || !ch_blocked(cur_r, pair_diff(cur_r, uni_r, bip_r),
						start_pin_role_o, ref_pin_role_o)) begin
						conv_start_o   <= 1'b1;
						conv_channel_o <= {cur_r[3:1], cur_r[0] &
							!pair_diff(cur_r, uni_r, bip_r)};
						conv_diff_o    <= !do_temp_r && pair_diff(cur_r, uni_r, bip_r);
						conv_temp_o    <= do_temp_r;
						state_r        <= adc_seq_pkg::ST_WAIT;
					end else begin
						state_r <= adc_seq_pkg::ST_STEP;
					end
				end
				adc_seq_pkg::ST_WAIT: begin
					if (conv_done_i)
						state_r <= adc_seq_pkg::ST_STEP;
				end
				adc_seq_pkg::ST_STEP: begin
					if (cur_temp_r) begin
						do_temp_r  <= 1'b0;
						cur_temp_r <= 1'b0;
						state_r    <= adc_seq_pkg::ST_ISSUE;
					end else begin
						cur_r   <= (conv_r[adc_seq_pkg::SCAN_HI:adc_seq_pkg::SCAN_LO] ==
							adc_seq_pkg::SCAN_REPEAT) ? cur_r : nch;
						rep_r   <= rep_r - 5'd1;
						open_r  <= !seq_done;
						state_r <= (seq_done || mode_r == adc_seq_pkg::MODE_PIN_SINGLE) ?
							adc_seq_pkg::ST_IDLE : adc_seq_pkg::ST_ISSUE;
					end
				end
				default: state_r <= adc_seq_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// End-of-conversion flag; a completion in the same cycle as a select
	// or start fall wins, so no finished sequence goes unflagged
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			eoc_n_o <= 1'b1;
		else if (mode_r == adc_seq_pkg::MODE_SCLK)
			eoc_n_o <= 1'b1;
		else if (state_r == adc_seq_pkg::ST_STEP && !cur_temp_r &&
			(seq_done || mode_r == adc_seq_pkg::MODE_PIN_SINGLE))
			eoc_n_o <= 1'b0;
		else if (cs_fall || cnv_fall)
			eoc_n_o <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Result storage
	assign push     = conv_done_i && state_r == adc_seq_pkg::ST_WAIT && !cur_temp_r;
	assign pop_fifo = tx_pop && !temp_valid_r && count_r != 5'd0 && rd_lo_r;
	assign head     = temp_valid_r ? temp_word_r :
		(count_r == 5'd0 ? 16'h0000 : mem_r[rd_ptr_r]);
	assign tx_byte  = temp_valid_r ? (temp_lo_r ? head[7:0] : head[15:8]) :
		(rd_lo_r ? head[7:0] : head[15:8]);

	always_ff @(posedge core_clk_i) begin
		if (push)
			mem_r[wr_ptr_r] <= fmt_result(conv_code_i,
				conv_diff_o && bip_r[~conv_channel_o[3:1]]);
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || (rx_valid && rx_first && rx_byte[7:4] == adc_seq_pkg::PFX_RST)) begin
			wr_ptr_r <= 4'h0;
			rd_ptr_r <= 4'h0;
			count_r  <= 5'd0;
			rd_lo_r  <= 1'b0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 4'h1;
			if (push && count_r == 5'(adc_seq_pkg::FIFO_DEPTH)) begin
				rd_ptr_r <= rd_ptr_r + 4'h1;
				rd_lo_r  <= 1'b0;
			end else if (pop_fifo) begin
				rd_ptr_r <= rd_ptr_r + 4'h1;
				rd_lo_r  <= 1'b0;
				count_r  <= push ? count_r : count_r - 5'd1;
			end else begin
				if (push)
					count_r <= count_r + 5'd1;
				if (tx_pop && !temp_valid_r && count_r != 5'd0)
					rd_lo_r <= 1'b1;
			end
		end
	end

	// Temperature slot is read ahead of the queue
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			temp_word_r  <= 16'h0000;
			temp_valid_r <= 1'b0;
			temp_lo_r    <= 1'b0;
		end else if (conv_done_i && state_r == adc_seq_pkg::ST_WAIT && cur_temp_r) begin
			temp_word_r  <= fmt_result(conv_code_i, 1'b1);
			temp_valid_r <= 1'b1;
			temp_lo_r    <= 1'b0;
		end else if (tx_pop && temp_valid_r) begin
			temp_lo_r    <= 1'b1;
			temp_valid_r <= !temp_lo_r;
		end
	end

endmodule : adc_serial_sequencer_fifo

// ### pkg/adc_seq_pkg.sv
/*
 * Shared constants and types of the converter sequencer: command byte
 * layout, clock modes, scan modes, reset values and result formats.
 * Assumes a single core clock; no other file defines these names.
 */
package adc_seq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sequencer states, Gray order idle-issue-wait-step
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b11,
		ST_STEP  = 2'b10
	} seq_state_type;

	////////////////////////////////////////////////////////////////////////
	// Clock modes
	localparam logic [1:0] MODE_PIN_SEQ    = 2'b00;
	localparam logic [1:0] MODE_PIN_SINGLE = 2'b01;
	localparam logic [1:0] MODE_SERIAL     = 2'b10;
	localparam logic [1:0] MODE_SCLK       = 2'b11;

	// Scan modes
	localparam logic [1:0] SCAN_TO_N   = 2'b00;
	localparam logic [1:0] SCAN_FROM_N = 2'b01;
	localparam logic [1:0] SCAN_REPEAT = 2'b10;
	localparam logic [1:0] SCAN_ONCE   = 2'b11;

	////////////////////////////////////////////////////////////////////////
	// Command byte fields
	localparam int CONV_FLAG   = 7;
	localparam int CHSEL_HI    = 6;
	localparam int CHSEL_LO    = 3;
	localparam int SCAN_HI     = 2;
	localparam int SCAN_LO     = 1;
	localparam int TEMP_BIT    = 0;
	localparam int MODE_HI     = 5;
	localparam int MODE_LO     = 4;
	localparam int REF_HI      = 3;
	localparam int REF_LO      = 2;
	localparam int DIFF_HI     = 1;
	localparam int DIFF_LO     = 0;
	localparam int NSCAN_HI    = 1;
	localparam int NSCAN_LO    = 0;
	localparam int RESET_BIT   = 3;

	localparam logic [1:0] PFX_SETUP = 2'b01;
	localparam logic [2:0] PFX_AVG   = 3'b001;
	localparam logic [3:0] PFX_RST   = 4'b0001;

	localparam logic [1:0] DIFFSEL_UNI     = 2'b10;
	localparam logic [1:0] DIFFSEL_BIP     = 2'b11;
	localparam logic [1:0] REFSEL_EXT_DIFF = 2'b11;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [1:0] MODE_RST   = MODE_SERIAL;
	localparam logic [1:0] REFSEL_RST = 2'b00;
	localparam logic [7:0] PAIR_RST   = 8'h00;
	localparam logic [7:0] CONV_RST   = 8'h00;
	localparam logic [1:0] NSCAN_RST  = 2'b00;

	////////////////////////////////////////////////////////////////////////
	// Channels, storage and result shape
	localparam logic [3:0] CH_FIRST     = 4'h0;
	localparam logic [3:0] CH_LAST      = 4'hf;
	localparam logic [3:0] CH_START_PIN = 4'hf;
	localparam logic [3:0] CH_REF_PIN   = 4'he;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW    = 4;
	localparam int WORD_W     = 16;
	localparam int CODE_W     = 13;
	localparam int BITS_PER_BYTE = 8;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;
	localparam logic [4:0] REPEAT_STEP = 5'd4;

endpackage : adc_seq_pkg

// ### design/serial_port.sv
/*
 * Four-wire serial slave: synchronises the pins, shifts command bytes in
 * on rising serial clock and result bytes out on falling serial clock.
 * Assumes the serial clock is at least four core clocks per half period.
 */
`timescale 1ns/1ps
module serial_port (
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       din_i,
	input  wire logic [7:0] tx_byte_i,
	output logic            tx_pop_o,
	output logic [7:0]      rx_byte_o,
	output logic            rx_valid_o,
	output logic            rx_first_o,
	output logic            cs_fall_o,
	output logic            dout_o,
	output logic            dout_oe_o
);

	logic [2:0] sclk_r;
	logic [2:0] cs_r;
	logic [1:0] din_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_sh_r;
	logic [7:0] tx_sh_r;
	logic       first_r;
	logic       fresh_r;
	logic       rise;
	logic       fall;
	logic       sel;

	////////////////////////////////////////////////////////////////////////
	// Two flops before use; third flop only for edge finding
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sclk_r <= 3'h0;
			cs_r   <= 3'h7;
			din_r  <= 2'h0;
		end else begin
			sclk_r <= {sclk_r[1:0], sclk_i};
			cs_r   <= {cs_r[1:0], cs_n_i};
			din_r  <= {din_r[0], din_i};
		end
	end

	assign sel       = !cs_r[1];
	assign rise      = sel && sclk_r[1] && !sclk_r[2];
	assign fall      = sel && !sclk_r[1] && sclk_r[2];
	assign cs_fall_o = cs_r[2] && !cs_r[1];

	////////////////////////////////////////////////////////////////////////
	// Receive side
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bit_cnt_r  <= 3'h0;
			rx_sh_r    <= 8'h00;
			rx_byte_o  <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_first_o <= 1'b0;
			first_r    <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			if (cs_fall_o) begin
				bit_cnt_r <= 3'h0;
				first_r   <= 1'b1;
			end else if (rise) begin
				rx_sh_r   <= {rx_sh_r[6:0], din_r[1]};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7) begin
					rx_byte_o  <= {rx_sh_r[6:0], din_r[1]};
					rx_valid_o <= 1'b1;
					rx_first_o <= first_r;
					first_r    <= 1'b0;
				end
			end
		end
	end

	// Byte leaves storage once its last bit has been sampled
	assign tx_pop_o = rise && (bit_cnt_r == 3'h7);

	////////////////////////////////////////////////////////////////////////
	// Transmit side; the fresh flag keeps the preloaded bit 7 when the
	// clock idles high and its first edge is a falling one
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tx_sh_r <= 8'h00;
			fresh_r <= 1'b0;
		end else if (cs_fall_o) begin
			tx_sh_r <= tx_byte_i;
			fresh_r <= 1'b1;
		end else if (fall) begin
			fresh_r <= 1'b0;
			if (bit_cnt_r != 3'h0)
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			else if (!fresh_r)
				tx_sh_r <= tx_byte_i;
		end
	end

	assign dout_o    = tx_sh_r[7];
	assign dout_oe_o = sel;

endmodule : serial_port

// ### test/adc_serial_sequencer_fifo_properties.sv
/*
 * Port checker for the converter sequencer, bound into its top module.
 * Assumes one core clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module adc_seq_checker (
	input wire logic                                   core_clk_i,
	input wire logic                                   rst_n_i,
	input wire logic                                   sclk_i,
	input wire logic                                   cs_n_i,
	input wire logic                                   din_i,
	input wire logic                                   dout_o,
	input wire logic                                   dout_oe_o,
	input wire logic                                   eoc_n_o,
	input wire logic                                   conversion_start_n_i,
	input wire logic                                   conv_start_o,
	input wire logic [3:0]                             conv_channel_o,
	input wire logic                                   conv_diff_o,
	input wire logic                                   conv_temp_o,
	input wire logic                                   conv_done_i,
	input wire logic signed [adc_seq_pkg::CODE_W-1:0] conv_code_i,
	input wire logic                                   osc_en_o,
	input wire logic                                   sclk_timed_o,
	input wire logic                                   start_pin_role_o,
	input wire logic                                   ref_pin_role_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////
	// Four samples cover the two sync flops on select
	property p_release;
		cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) && $past(cs_n_i, 3) |-> !dout_oe_o;
	endproperty
	a_release: assert property (p_release) else $error("dout driven while deselected");
	property p_drive;
		!cs_n_i && !$past(cs_n_i) && !$past(cs_n_i, 2) && !$past(cs_n_i, 3) |-> dout_oe_o;
	endproperty
	a_drive: assert property (p_drive) else $error("dout not driven while selected");
	property p_select;
		$fell(cs_n_i) |-> ##[1:4] eoc_n_o;
	endproperty
	a_select: assert property (p_select) else $error("flag not raised by select");
	property p_cause;
		$fell(eoc_n_o) |-> $past(conv_done_i) || $past(conv_done_i, 2) ||
			$past(conv_done_i, 3) || $past(conv_done_i, 4);
	endproperty
	a_cause: assert property (p_cause) else $error("flag low without completion");
	property p_mode11;
		sclk_timed_o |-> eoc_n_o;
	endproperty
	a_mode11: assert property (p_mode11) else $error("flag low in serial-clock mode");
	property p_osc;
		osc_en_o != sclk_timed_o;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator state wrong");
	property p_start_pin;
		conv_start_o && start_pin_role_o && !conv_temp_o |-> conv_channel_o != 4'hf;
	endproperty
	a_start_pin: assert property (p_start_pin) else $error("start pin converted");
	property p_pair_even;
		conv_start_o && conv_diff_o |-> !conv_channel_o[0] && !conv_temp_o;
	endproperty
	a_pair_even: assert property (p_pair_even) else $error("pair on odd channel");
	c_pair: cover property (conv_start_o && conv_diff_o);
	c_flag: cover property ($fell(eoc_n_o));
	c_pin: cover property (conv_start_o && start_pin_role_o);
endmodule : adc_seq_checker
bind adc_serial_sequencer_fifo adc_seq_checker u_adc_seq_checker (.*);

// ### test/spi_host_model.sv
/*
 * Serial host stand-in: idle-low clock of 320 ns period, frames of whole bytes.
 * Assumes dout is only meaningful while the device enables it.
 */
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic dout_i,
	input  wire logic dout_oe_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o
);
	logic last_r;
	logic miso;
	// Released line shows the inverse, so a stale bit never passes
	assign miso = dout_oe_i ? dout_i : ~last_r;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
		last_r = 1'b0;
	end
	// Clock stands still outside frames; all n bytes (one or two) in one frame
	task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_o = 1'b0;
		#160;
		for (int i = 0; i < 8 * n; i++) begin
			din_o = tx[15 - i]; // MSB first
			#160;
			sclk_o = 1'b1;
			rx = {rx[14:0], miso};
			last_r = miso;
			#160;
			sclk_o = 1'b0;
		end
		#160;
		cs_n_o = 1'b1;
		#160;
	endtask : frame
endmodule : spi_host_model

// ### test/test_adc_serial_sequencer_fifo.sv
/*
 * Self-checking bench of the converter sequencer with a serial host model.
 * Assumes the analog core answers each start after a fixed latency.
 */
`timescale 1ns/1ps
module test_adc_serial_sequencer_fifo;
	logic core_clk_i, rst_n_i, sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, eoc_n_o;
	logic conversion_start_n_i, conv_start_o, conv_diff_o, conv_temp_o, conv_done_i;
	logic osc_en_o, sclk_timed_o, start_pin_role_o, ref_pin_role_o;
	logic [3:0] conv_channel_o;
	logic signed [adc_seq_pkg::CODE_W-1:0] conv_code_i, next_code;
	logic [15:0] rx;
	int n_mismatch, total_checks, n_conv, n0;
	adc_serial_sequencer_fifo u_adc_serial_sequencer_fifo (.*);
	spi_host_model u_spi_host_model (.dout_i(dout_o), .dout_oe_i(dout_oe_o),
		.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	// Analog core stand-in; codes count up so order shows in the FIFO
	always @(posedge core_clk_i) begin
		if (conv_start_o === 1'b1) begin
			n_conv++;
			repeat (6) @(posedge core_clk_i);
			#1 conv_done_i = 1'b1;
			conv_code_i = next_code;
			@(posedge core_clk_i);
			#1 conv_done_i = 1'b0;
			next_code = next_code + 13'sh1;
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Host edges land 1 ns after a core edge, never on it
	task automatic send(input logic [15:0] tx, input int n);
		@(posedge core_clk_i);
		#1 u_spi_host_model.frame(tx, n, rx);
	endtask : send
	// Bounded wait, then the flag itself is judged
	task automatic wait_eoc(input string what);
		int i;
		i = 0;
		while (eoc_n_o !== 1'b0 && i < 2000) begin
			@(posedge core_clk_i);
			#1 i++;
		end
		chk(what, 16'h0000, {15'h0, eoc_n_o});
	endtask : wait_eoc
	task automatic pulse_start;
		@(posedge core_clk_i);
		#1 conversion_start_n_i = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#1 conversion_start_n_i = 1'b1;
	endtask : pulse_start
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("osc", 16'h1, {15'h0, osc_en_o});
		chk("pin role", 16'h0, {15'h0, start_pin_role_o});
		chk("oe idle", 16'h0, {15'h0, dout_oe_o});
		send(16'h0000, 1);
		chk("empty", 16'h0000, rx);
	endtask : t_reset
	task automatic t_serial;
		next_code = 13'sh0abc;
		n0 = n_conv;
		send(16'h9e00, 1);
		wait_eoc("eoc single");
		chk("count", 16'h1, 16'(n_conv - n0));
		chk("channel", 16'h3, {12'h0, conv_channel_o});
		send(16'h0000, 2);
		chk("word", 16'h0abc, rx);
		chk("eoc cs", 16'h1, {15'h0, eoc_n_o});
		send(16'h0000, 1);
		chk("popped", 16'h0000, rx);
	endtask : t_serial
	task automatic t_fifo;
		next_code = 13'sh0010;
		send(16'h8700, 1);
		wait_eoc("eoc temp");
		send(16'h0000, 2);
		chk("temp first", 16'h0010, rx);
		send(16'h0000, 2);
		chk("after temp", 16'h0011, rx);
		next_code = 13'sh0020;
		send(16'hf800, 1);
		wait_eoc("eoc scan");
		send(16'h8600, 1);
		wait_eoc("eoc extra");
		send(16'h0000, 2);
		chk("overwrite", 16'h0021, rx);
		send(16'h1800, 1);
		send(16'h0000, 2);
		chk("cleared", 16'h0000, rx);
	endtask : t_fifo
	task automatic t_pairs;
		send(16'h6240, 2);
		next_code = -13'sh5;
		send(16'h9600, 1);
		wait_eoc("eoc uni");
		chk("diff", 16'h1, {15'h0, conv_diff_o});
		send(16'h0000, 2);
		chk("uni neg", 16'h0000, rx);
		send(16'h6200, 2);
		send(16'h6340, 2);
		next_code = -13'sh5;
		send(16'h9600, 1);
		wait_eoc("eoc bip");
		send(16'h0000, 2);
		chk("bip neg", 16'h0ffb, rx);
		n0 = n_conv;
		send(16'h2100, 1);
		send(16'h8400, 1);
		wait_eoc("eoc repeat");
		chk("repeat count", 16'h8, 16'(n_conv - n0));
	endtask : t_pairs
	task automatic t_pins;
		send(16'h5000, 1);
		chk("pin role", 16'h1, {15'h0, start_pin_role_o});
		n0 = n_conv;
		send(16'h9e00, 1);
		repeat (20) @(posedge core_clk_i);
		chk("no serial start", 16'h0, 16'(n_conv - n0));
		pulse_start();
		wait_eoc("eoc each");
		chk("one conv", 16'h1, 16'(n_conv - n0));
		pulse_start();
		chk("eoc pin", 16'h1, {15'h0, eoc_n_o});
		wait_eoc("eoc again");
		send(16'h4000, 1);
		send(16'h8800, 1);
		n0 = n_conv;
		pulse_start();
		wait_eoc("eoc seq");
		chk("seq count", 16'h2, 16'(n_conv - n0));
		send(16'h7c00, 1);
		chk("sclk timed", 16'h1, {15'h0, sclk_timed_o});
		chk("ref role", 16'h1, {15'h0, ref_pin_role_o});
		chk("eoc m11", 16'h1, {15'h0, eoc_n_o});
	endtask : t_pins
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		rst_n_i = 1'b0;
		conversion_start_n_i = 1'b1;
		conv_done_i = 1'b0;
		conv_code_i = 13'sh0;
		next_code = 13'sh0;
		repeat (5) @(posedge core_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		t_reset();
		t_serial();
		t_fifo();
		t_pairs();
		t_pins();
		end_sim();
	end
endmodule : test_adc_serial_sequencer_fifo
